/* File: axi_lite_reg_port.sv */
// AXI4-Lite slave front end: one write and one read at a time
// assumes the register file answers a read index with a word in the same cycle
`timescale 1ns/1ps
module axi_lite_reg_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// write address and data
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register file side
	output irq_ctrl_pkg::reg_wr_t wr,
	output logic [7:0] rd_idx,
	input wire logic [31:0] rd_word
);
	logic aw_got_reg;
	logic w_got_reg;
	logic [irq_ctrl_pkg::ADDR_W-1:0] waddr_reg;
	logic rd_pend_reg;
	logic rd_ok_reg;
	wire logic aw_hs = awvalid && awready;
	wire logic w_hs = wvalid && wready;
	wire logic ar_hs = arvalid && arready;
	wire logic [7:0] widx_w = waddr_reg[irq_ctrl_pkg::ADDR_W-1:2];
	wire logic wr_ok_w = (waddr_reg[1:0] == 2'h0) && irq_ctrl_pkg::idx_mapped(widx_w);
	wire logic wr_fire_w = aw_got_reg && w_got_reg && !bvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= '0;
			wr <= '0;
			bvalid <= 1'b0;
			bresp <= irq_ctrl_pkg::RESP_OKAY;
		end else if (ce) begin
			wr.en <= 1'b0;
			if (aw_hs) begin
				aw_got_reg <= 1'b1;
				awready <= 1'b0;
				waddr_reg <= awaddr;
			end
			if (w_hs) begin
				w_got_reg <= 1'b1;
				wready <= 1'b0;
				wr.data <= wdata;
				wr.strb <= wstrb;
			end
			if (wr_fire_w) begin
				// unmapped or unaligned writes change nothing and answer with an error
				wr.en <= wr_ok_w;
				wr.idx <= widx_w;
				bvalid <= 1'b1;
				bresp <= wr_ok_w ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// reads have no side effects; the word is sampled one cycle after the index settles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b1;
			rd_idx <= 8'h00;
			rd_pend_reg <= 1'b0;
			rd_ok_reg <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= irq_ctrl_pkg::RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				arready <= 1'b0;
				rd_idx <= araddr[irq_ctrl_pkg::ADDR_W-1:2];
				rd_ok_reg <= araddr[1:0] == 2'h0;
				rd_pend_reg <= 1'b1;
			end
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				rvalid <= 1'b1;
				if (rd_ok_reg && irq_ctrl_pkg::idx_mapped(rd_idx)) begin
					rdata <= rd_word;
					rresp <= irq_ctrl_pkg::RESP_OKAY;
				end else begin
					rdata <= 32'h0000_0000;
					rresp <= irq_ctrl_pkg::RESP_SLVERR;
				end
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

/* File: core_model.sv */
// processor core stand-in: instruction boundaries, handler returns, stack pointer
// assumes the controller's strobes are one-cycle pulses on clk
`timescale 1ns/1ps
module core_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control and controller side
	input wire logic slow,
	input wire logic core_hold,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic vector_go,
	output logic core_boundary,
	output logic core_ret_req,
	output logic [7:0] sp
);
	logic [1:0] ic;
	logic [1:0] rc;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_boundary <= 1'h0;
			core_ret_req <= 1'h0;
			sp <= 8'h00;
			ic <= 2'h0;
			rc <= 2'h0;
		end else begin
			core_boundary <= !core_hold && ic == 2'h0;
			ic <= (ic != 2'h0) ? ic - 2'h1 : (slow ? 2'h2 : 2'h0);
			core_ret_req <= rc == 2'h1;
			rc <= vector_go ? 2'h3 : (rc != 2'h0 ? rc - 2'h1 : 2'h0);
			sp <= sp - {7'h0, stack_push} + {7'h0, stack_pop};
		end
	end
endmodule

/* File: ext_pin_trigger.sv */
// synchroniser and sense detector for one external interrupt pin
// assumes the pin is asynchronous; the sense setting comes from the same clock
`timescale 1ns/1ps
module ext_pin_trigger (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// pin and setting
	input wire logic pin,
	input wire irq_ctrl_pkg::sense_t sense,
	// results
	output logic level_low,
	output logic edge_hit
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic stable_reg;
	logic edge_reg;
	wire logic chg_w = (s2_reg == s3_reg) && (s3_reg != stable_reg);
	wire logic rise_w = chg_w && s3_reg;
	wire logic fall_w = chg_w && !s3_reg;
	logic edge_next;

	// the pin is watched even when driven as an output, which gives a software interrupt
	always_comb begin
		unique case (sense)
			irq_ctrl_pkg::SENSE_ANY: edge_next = chg_w;
			irq_ctrl_pkg::SENSE_FALL: edge_next = fall_w;
			irq_ctrl_pkg::SENSE_RISE: edge_next = rise_w;
			irq_ctrl_pkg::SENSE_LOW: edge_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= irq_ctrl_pkg::PIN_IDLE;
			s2_reg <= irq_ctrl_pkg::PIN_IDLE;
			s3_reg <= irq_ctrl_pkg::PIN_IDLE;
			stable_reg <= irq_ctrl_pkg::PIN_IDLE;
			edge_reg <= 1'b0;
		end else if (ce) begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (chg_w) begin
				stable_reg <= s3_reg;
			end
			edge_reg <= edge_next;
		end
	end

	assign level_low = !stable_reg;
	assign edge_hit = edge_reg;
endmodule

/* File: irq_ctrl_pkg.sv */
// constants, field layouts and carrier types of the timer and pin interrupt controller
// assumes one 40 MHz clock domain and an AXI4-Lite master with 32-bit data
package irq_ctrl_pkg;

	localparam int unsigned ADDR_W = 10;

	// register indices; byte address is four times the index
	localparam logic [7:0] TIMER_IRQ_FLAGS_IDX = 8'h38;
	localparam logic [7:0] TIMER_IRQ_ENABLE_IDX = 8'h39;
	localparam logic [7:0] EXT_IRQ_CTRL_IDX = 8'h3A;
	localparam logic [7:0] IRQ_STATE_IDX = 8'h3B;

	// timer flag and enable bit positions, shared by both registers
	localparam int T1_OVF_POS = 7;
	localparam int T1_CMP_POS = 6;
	localparam int T1_CAP_POS = 3;
	localparam int T0_OVF_POS = 1;
	localparam logic [7:0] TIMER_BITS_MASK = 8'hCA;
	localparam logic [7:0] TIMER_IRQ_ENABLE_RST = 8'h00;
	localparam logic [7:0] TIMER_IRQ_FLAGS_RST = 8'h00;

	// pin interrupt control word: sense a [1:0], sense b [3:2], enables, global enable
	localparam int SENSE_A_LSB = 0;
	localparam int SENSE_B_LSB = 2;
	localparam int EXT_A_EN_POS = 4;
	localparam int EXT_B_EN_POS = 5;
	localparam int GIE_POS = 7;
	localparam logic [7:0] EXT_CTRL_MASK = 8'h3F;
	localparam logic [7:0] EXT_CTRL_RST = 8'h00;
	localparam logic GIE_RST = 1'b0;
	localparam logic PIN_IDLE = 1'b1;

	// sources in priority order: lowest vector first
	localparam int NUM_SRC = 6;
	localparam logic [3:0] VEC_ADDR [NUM_SRC] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
	// flag positions of the four timer sources (capture, compare, t1 overflow, t0 overflow)
	localparam int FLAG_POS [4] = '{T1_CAP_POS, T1_CMP_POS, T1_OVF_POS, T0_OVF_POS};

	// entry and return each span four clock cycles
	localparam int unsigned ENTRY_CYCLES = 4;
	localparam int unsigned RETURN_CYCLES = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_ANY = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} sense_t;

	typedef struct packed {
		logic t1_wrap;
		logic t1_tick;
		logic t1_pwm_mode;
		logic t1_capture;
		logic t0_wrap;
	} timer_evt_t;

	typedef struct packed {
		logic en;
		logic [7:0] idx;
		logic [31:0] data;
		logic [3:0] strb;
	} reg_wr_t;

	function automatic logic idx_mapped(logic [7:0] idx);
		return idx == TIMER_IRQ_FLAGS_IDX || idx == TIMER_IRQ_ENABLE_IDX ||
			idx == EXT_IRQ_CTRL_IDX || idx == IRQ_STATE_IDX;
	endfunction

endpackage

/* File: testbench.sv */
// self-checking bench: register bus, timer events, pins, core stand-in
// assumes the controller and core_model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected %0t got %h want %h", $time, a, b); end end
module testbench;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic ext_irq_pin_a = 1'h1, ext_irq_pin_b = 1'h1, slow = 1'h0;
	logic [9:0] awaddr = 10'h000, araddr = 10'h000;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [15:0] t1_count = 16'h0000, t1_compare_value = 16'h0000;
	irq_ctrl_pkg::timer_evt_t tmr = '0;
	logic awready, wready, bvalid, arready, rvalid, core_hold, stack_push, stack_pop;
	logic vector_go, gie, core_boundary, core_ret_req, stack_hi_byte;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] vector_addr;
	logic [7:0] sp;
	logic [12:0] vq[$];
	int n_fail = 0, samples_checked = 0;
	localparam logic [9:0] A_FLG = {irq_ctrl_pkg::TIMER_IRQ_FLAGS_IDX, 2'h0};
	localparam logic [9:0] A_EN = {irq_ctrl_pkg::TIMER_IRQ_ENABLE_IDX, 2'h0};
	localparam logic [9:0] A_EXT = {irq_ctrl_pkg::EXT_IRQ_CTRL_IDX, 2'h0};
	timer_ext_interrupt_control timer_ext_interrupt_control_i (.clk, .rst, .ce(1'h1),
		.awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.tmr, .t1_count, .t1_compare_value, .ext_irq_pin_a, .ext_irq_pin_b,
		.core_boundary, .core_ret_req, .core_hold, .stack_push, .stack_pop,
		.stack_hi_byte, .vector_go, .vector_addr, .gie);
	core_model core_model_i (.clk, .rst, .slow, .core_hold, .stack_push, .stack_pop,
		.vector_go, .core_boundary, .core_ret_req, .sp);
	initial forever #12.5 clk = ~clk;
	always @(negedge clk) if (vector_go === 1'h1) vq.push_back({sp, gie, vector_addr});
	// pc bytes: push low then high, pop high then low; sp parity tells which is due
	always @(negedge clk) if (stack_push === 1'h1 || stack_pop === 1'h1)
		`CHK(stack_hi_byte, stack_push ? sp[0] : !sp[0])
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		resp = bresp;
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] x);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		resp = rresp;
		`CHK(d, {24'h0, x})
	endtask
	task automatic ev(input logic [4:0] e);
		@(posedge clk);
		tmr <= e;
		@(posedge clk);
		tmr <= '0;
		repeat (6) @(posedge clk);
	endtask
	// each vector: stack two bytes down, global enable cleared, then balanced
	task automatic vchk(input logic [3:0] ex[$]);
		repeat (80) @(posedge clk);
		`CHK(vq.size(), ex.size())
		foreach (ex[i]) `CHK(vq[i], {8'hFE, 1'h0, ex[i]})
		vq.delete();
		`CHK(sp, 8'h00)
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		// the sequence needs about 700 cycles; leave ample margin
		repeat (3000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rdc(A_EN, 8'h00);
		rdc(A_FLG, 8'h00);
		wr(A_EN, 8'hFF);
		`CHK(resp, irq_ctrl_pkg::RESP_OKAY)
		rdc(A_EN, 8'hCA);
		rdc(10'h3FC, 8'h00);
		`CHK(resp, irq_ctrl_pkg::RESP_SLVERR)
		t1_count <= 16'h1234;
		t1_compare_value <= 16'h1234;
		ev(5'h08);
		rdc(A_FLG, 8'h40);
		t1_count <= 16'h0000;
		ev(5'h0C);
		rdc(A_FLG, 8'hC0);
		wr(A_FLG, 8'h80);
		rdc(A_FLG, 8'h40);
		ev(5'h10);
		ev(5'h02);
		ev(5'h01);
		wr(A_FLG, 8'h35);
		rdc(A_FLG, 8'hCA);
		wr(A_FLG, 8'h02);
		rdc(A_FLG, 8'hC8);
		wr(A_EXT, 8'h80);
		vchk('{4'h3, 4'h4, 4'h5});
		rdc(A_FLG, 8'h00);
		rdc(A_EXT, 8'h80);
		slow <= 1'h1;
		ev(5'h01);
		vchk('{4'h6});
		slow <= 1'h0;
		for (logic [7:0] s = 8'h01; s < 8'h04; s++) begin
			wr(A_EXT, 8'h90 | s);
			ext_irq_pin_a <= 1'h0;
			repeat (30) @(posedge clk);
			ext_irq_pin_a <= 1'h1;
			repeat (30) @(posedge clk);
			`CHK(vq.size(), (s == 8'h01) ? 2 : 1)
			`CHK(vq[0][3:0], 4'h1)
			vq.delete();
		end
		wr(A_EXT, 8'h90);
		ext_irq_pin_a <= 1'h0;
		repeat (60) @(posedge clk);
		`CHK(vq.size() > 1, 1'h1)
		ext_irq_pin_a <= 1'h1;
		repeat (30) @(posedge clk);
		vq.delete();
		wr(A_EXT, 8'h3A);
		ext_irq_pin_b <= 1'h0;
		ext_irq_pin_a <= 1'h0;
		ev(5'h01);
		ext_irq_pin_b <= 1'h1;
		ext_irq_pin_a <= 1'h1;
		repeat (6) @(posedge clk);
		wr(A_EXT, 8'hBA);
		vchk('{4'h1, 4'h2, 4'h6});
		wrap_up();
	end
endmodule

/* File: timer_ext_interrupt_control.sv */
// interrupt controller for two timers and two pins, with the entry and return sequencer
// assumes the core signals instruction boundaries and return instructions on this clock
//
// Summary of operation
// - timer1 overflow enabled and pending takes vector 5
// - compare match enabled and pending takes vector 4
// - capture enabled and pending takes vector 3
// - timer0 overflow enabled and pending takes vector 6
// - enable bits 7, 6, 3, 1, reset zero
// - other bits ignore writes, read zero
// - timer1 overflow sets flag; PWM: leaving zero
// - timer1 count equals compare value sets flag
// - capture event sets capture flag
// - timer0 overflow sets its flag
// - flag clears when its vector is taken
// - writing one clears flag, zero keeps it
// - pin activity counts even when driven
// - pin triggers on falling, rising or low
// - low level requests for as long as held
// - vector runs at least four cycles after flag
// - entry pushes two PC bytes, stack minus two
// - multi-cycle instruction finishes before entry
// - return: four cycles, two pops, enable set
// - one main instruction runs after each return
// - entry clears the global interrupt enable
// - disabled flags stay pending until served or cleared
// - sense 00 low, 01 change, 10 fall, 11 rise
`timescale 1ns/1ps
module timer_ext_interrupt_control (
	// clock, reset, clock enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite register bus
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// timer events and count
	input wire irq_ctrl_pkg::timer_evt_t tmr,
	input wire logic [15:0] t1_count,
	input wire logic [15:0] t1_compare_value,
	// external interrupt pins
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	// processor core
	input wire logic core_boundary,
	input wire logic core_ret_req,
	output logic core_hold,
	output logic stack_push,
	output logic stack_pop,
	output logic stack_hi_byte,
	output logic vector_go,
	output logic [3:0] vector_addr,
	output logic gie
);
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_ENTRY = 4'h2,
		ST_RETURN = 4'h4,
		ST_AFTER_RET = 4'h8
	} seq_state_t;

	localparam int NS = irq_ctrl_pkg::NUM_SRC;
	// counts stop one short: the take cycle itself is the first of the four
	localparam logic [2:0] ENTRY_LAST = 3'(irq_ctrl_pkg::ENTRY_CYCLES - 2);
	localparam logic [2:0] RETURN_LAST = 3'(irq_ctrl_pkg::RETURN_CYCLES - 2);

	irq_ctrl_pkg::reg_wr_t wr;
	logic [7:0] rd_idx;
	logic [31:0] rd_word;
	seq_state_t st_reg;
	seq_state_t st_next;
	logic [2:0] cnt_reg;
	logic [7:0] enable_reg;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] ctrl_reg;
	logic gie_reg;
	logic [1:0] edge_latch_reg;
	logic [NS-1:0] sel_reg;
	logic hold_reg;
	logic push_reg;
	logic pop_reg;
	logic hi_reg;
	logic go_reg;
	logic [3:0] vec_reg;
	logic [1:0] level_low_w;
	logic [1:0] edge_hit_w;
	logic [3:0] vec_w;
	logic [7:0] flag_set_w;
	logic [7:0] flag_clr_w;

	axi_lite_reg_port bus (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr(wr),
		.rd_idx(rd_idx),
		.rd_word(rd_word)
	);

	ext_pin_trigger pin_a (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(ext_irq_pin_a),
		.sense(irq_ctrl_pkg::sense_t'(ctrl_reg[irq_ctrl_pkg::SENSE_A_LSB +: 2])),
		.level_low(level_low_w[0]),
		.edge_hit(edge_hit_w[0])
	);

	ext_pin_trigger pin_b (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(ext_irq_pin_b),
		.sense(irq_ctrl_pkg::sense_t'(ctrl_reg[irq_ctrl_pkg::SENSE_B_LSB +: 2])),
		.level_low(level_low_w[1]),
		.edge_hit(edge_hit_w[1])
	);

	// register write decode
	wire logic wr_lane0 = wr.en && wr.strb[0];
	wire logic wr_flags = wr_lane0 && wr.idx == irq_ctrl_pkg::TIMER_IRQ_FLAGS_IDX;
	wire logic wr_enable = wr_lane0 && wr.idx == irq_ctrl_pkg::TIMER_IRQ_ENABLE_IDX;
	wire logic wr_ctrl = wr_lane0 && wr.idx == irq_ctrl_pkg::EXT_IRQ_CTRL_IDX;

	wire logic [1:0] ext_en_w = {ctrl_reg[irq_ctrl_pkg::EXT_B_EN_POS],
		ctrl_reg[irq_ctrl_pkg::EXT_A_EN_POS]};
	wire logic [1:0] ext_level_w = {ctrl_reg[irq_ctrl_pkg::SENSE_B_LSB +: 2] == 2'h0,
		ctrl_reg[irq_ctrl_pkg::SENSE_A_LSB +: 2] == 2'h0};

	// PWM mode flags the count as it leaves zero
	wire logic t1_ovf_set = tmr.t1_pwm_mode ? (tmr.t1_tick && t1_count == 16'h0000) :
		tmr.t1_wrap;
	// compare match on each count step
	wire logic t1_cmp_set = tmr.t1_tick && (t1_count == t1_compare_value);

	logic [NS-1:0] pend_w;
	// level requests are never latched, only the pin level counts
	assign pend_w[1:0] = ext_en_w & ((ext_level_w & level_low_w) |
		(~ext_level_w & edge_latch_reg));

	// entry ends with the vector taken; hardware clears that source
	wire logic vec_take_w = st_reg == ST_ENTRY && cnt_reg == ENTRY_LAST;

	always_comb begin
		flag_set_w = 8'h00;
		flag_set_w[irq_ctrl_pkg::T1_OVF_POS] = t1_ovf_set;
		flag_set_w[irq_ctrl_pkg::T1_CMP_POS] = t1_cmp_set;
		flag_set_w[irq_ctrl_pkg::T1_CAP_POS] = tmr.t1_capture;
		flag_set_w[irq_ctrl_pkg::T0_OVF_POS] = tmr.t0_wrap;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tflag
			localparam int P = irq_ctrl_pkg::FLAG_POS[gi];
			// request needs its enable and its flag
			assign pend_w[gi + 2] = flags_reg[P] && enable_reg[P];
			// clear by vector or by writing one
			assign flag_clr_w[P] = (wr_flags && wr.data[P]) || (vec_take_w && sel_reg[gi + 2]);
			// set wins over any clear in the same cycle
			assign flags_next[P] = (flags_reg[P] && !flag_clr_w[P]) || flag_set_w[P];
		end
	endgenerate

	assign flags_next[5:4] = 2'h0;
	assign flags_next[2] = 1'b0;
	assign flags_next[0] = 1'b0;
	assign flag_clr_w[5:4] = 2'h0;
	assign flag_clr_w[2] = 1'b0;
	assign flag_clr_w[0] = 1'b0;

	// lowest index, hence lowest vector, wins
	wire logic [NS-1:0] win_w = pend_w & (~pend_w + 6'h01);
	always_comb begin
		vec_w = 4'h0;
		for (int i = 0; i < NS; i++) begin
			if (win_w[i]) begin
				vec_w = irq_ctrl_pkg::VEC_ADDR[i];
			end
		end
	end

	// entry starts only at an instruction boundary
	wire logic take_w = core_boundary && gie_reg && (|pend_w) &&
		((st_reg == ST_RUN && !core_ret_req) || st_reg == ST_AFTER_RET);
	wire logic ret_w = core_ret_req && st_reg == ST_RUN;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_RUN: begin
				if (ret_w) begin
					st_next = ST_RETURN;
				end else if (take_w) begin
					st_next = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				if (cnt_reg == ENTRY_LAST) begin
					st_next = ST_RUN;
				end
			end
			ST_RETURN: begin
				if (cnt_reg == RETURN_LAST) begin
					st_next = ST_AFTER_RET;
				end
			end
			// wait for one main instruction to end
			ST_AFTER_RET: begin
				if (take_w) begin
					st_next = ST_ENTRY;
				end else if (core_boundary) begin
					st_next = ST_RUN;
				end
			end
			default: st_next = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_RUN;
			cnt_reg <= 3'h0;
			sel_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
			cnt_reg <= (st_next != st_reg) ? 3'h0 : cnt_reg + 3'h1;
			if (take_w) begin
				sel_reg <= win_w;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_reg <= irq_ctrl_pkg::TIMER_IRQ_ENABLE_RST;
			flags_reg <= irq_ctrl_pkg::TIMER_IRQ_FLAGS_RST;
			ctrl_reg <= irq_ctrl_pkg::EXT_CTRL_RST;
		end else if (ce) begin
			flags_reg <= flags_next;
			if (wr_enable) begin
				enable_reg <= wr.data[7:0] & irq_ctrl_pkg::TIMER_BITS_MASK;
			end
			if (wr_ctrl) begin
				ctrl_reg <= wr.data[7:0] & irq_ctrl_pkg::EXT_CTRL_MASK;
			end
		end
	end

	// pin edges are remembered until served; level mode keeps no memory
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			edge_latch_reg <= 2'h0;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (ext_level_w[i]) begin
					edge_latch_reg[i] <= 1'b0;
				end else if (edge_hit_w[i]) begin
					edge_latch_reg[i] <= 1'b1;
				end else if (vec_take_w && sel_reg[i]) begin
					edge_latch_reg[i] <= 1'b0;
				end
			end
		end
	end

	// global enable: entry clears it, return and software set it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gie_reg <= irq_ctrl_pkg::GIE_RST;
		end else if (ce) begin
			if (take_w) begin
				gie_reg <= 1'b0;
			// set at the end of the return
			end else if (st_reg == ST_RETURN && cnt_reg == RETURN_LAST) begin
				gie_reg <= 1'b1;
			end else if (wr_ctrl) begin
				gie_reg <= wr.data[irq_ctrl_pkg::GIE_POS];
			end
		end
	end

	// core-facing strobes, all registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			hi_reg <= 1'b0;
			go_reg <= 1'b0;
			vec_reg <= 4'h0;
		end else if (ce) begin
			hold_reg <= st_next == ST_ENTRY || st_next == ST_RETURN;
			// low byte on the take edge, high byte next, vector two later
			push_reg <= take_w || (st_reg == ST_ENTRY && cnt_reg == 3'h0);
			// high byte pops first, then low
			pop_reg <= ret_w || (st_reg == ST_RETURN && cnt_reg == 3'h0);
			hi_reg <= ret_w || (st_reg == ST_ENTRY && cnt_reg == 3'h0);
			go_reg <= vec_take_w;
			if (take_w) begin
				vec_reg <= vec_w;
			end
		end
	end

	assign core_hold = hold_reg;
	assign stack_push = push_reg;
	assign stack_pop = pop_reg;
	assign stack_hi_byte = hi_reg;
	assign vector_go = go_reg;
	assign vector_addr = vec_reg;
	assign gie = gie_reg;

	assign rd_word =
		(rd_idx == irq_ctrl_pkg::TIMER_IRQ_FLAGS_IDX) ? {24'h0, flags_reg} :
		(rd_idx == irq_ctrl_pkg::TIMER_IRQ_ENABLE_IDX) ? {24'h0, enable_reg} :
		(rd_idx == irq_ctrl_pkg::EXT_IRQ_CTRL_IDX) ? {24'h0, gie_reg, 1'b0, ctrl_reg[5:0]} :
		(rd_idx == irq_ctrl_pkg::IRQ_STATE_IDX) ? {22'h0, st_reg, pend_w} : 32'h0000_0000;

	// checks; a cycle with the clock enable low abandons them
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);

	sequence entry_s;
		push_reg && !hi_reg && !gie_reg ##1 push_reg && hi_reg ##1 !push_reg ##1 go_reg;
	endsequence

	sequence return_s;
		pop_reg && hi_reg ##1 pop_reg && !hi_reg ##1 !pop_reg ##1 gie_reg && st_reg == ST_AFTER_RET;
	endsequence

	t0_flag_set_a: assert property (tmr.t0_wrap |=> flags_reg[irq_ctrl_pkg::T0_OVF_POS])
		else $error("timer0 overflow did not set its flag");
	pwm_ovf_set_a: assert property (tmr.t1_pwm_mode && tmr.t1_tick && t1_count == 16'h0000 |=>
		flags_reg[irq_ctrl_pkg::T1_OVF_POS])
		else $error("pwm overflow flag missing");
	cmp_flag_set_a: assert property (t1_cmp_set |=> flags_reg[irq_ctrl_pkg::T1_CMP_POS])
		else $error("compare match flag missing");
	cap_flag_set_a: assert property (tmr.t1_capture |=> flags_reg[irq_ctrl_pkg::T1_CAP_POS])
		else $error("capture flag missing");
	sw_clear_a: assert property (wr_flags && wr.data[irq_ctrl_pkg::T0_OVF_POS] && !tmr.t0_wrap |=>
		!flags_reg[irq_ctrl_pkg::T0_OVF_POS])
		else $error("write of one did not clear flag");
	reserved_zero_a: assert property (((flags_reg | enable_reg) & ~irq_ctrl_pkg::TIMER_BITS_MASK)
		== 8'h00)
		else $error("reserved bit set");
	entry_seq_a: assert property (take_w |=> entry_s)
		else $error("entry sequence wrong");
	return_seq_a: assert property (ret_w |=> return_s)
		else $error("return sequence wrong");
	one_instr_a: assert property (st_reg == ST_AFTER_RET && !core_boundary |=>
		st_reg != ST_ENTRY)
		else $error("entry before one main instruction");
	lowest_vec_a: assert property (take_w |=> vec_reg == $past(vec_w) &&
		$past(pend_w) == ($past(pend_w) & ~($past(win_w) - 6'h01)))
		else $error("priority order broken");
	hw_clear_a: assert property (vec_take_w && sel_reg[5] && !tmr.t0_wrap |=>
		!flags_reg[irq_ctrl_pkg::T0_OVF_POS] && go_reg)
		else $error("vectored flag not cleared");
endmodule
